//--- rtl/frc_defines.vh
// Constants for the fault routing and counting block: APB offsets, field
// positions, reset values and clock monitor timing.
// Assumes a 20 MHz system clock and an 8-bit APB byte address.
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH

// ============================================================
// Sizes
`define FRC_ENGINES      4
`define FRC_MODULES      16
`define FRC_SRC_W        25
`define FRC_CNT_W        5

// ============================================================
// Register byte offsets
`define FRC_OFF_CTRL     8'h00
`define FRC_OFF_STATUS   8'h04
`define FRC_OFF_SRC      8'h08
`define FRC_OFF_EVT_EN   8'h0C
`define FRC_OFF_EXT_CFG  8'h10
`define FRC_OFF_ACMP_CFG 8'h14
`define FRC_OFF_ATHR_LO  8'h18
`define FRC_OFF_ATHR_HI  8'h1C
`define FRC_OFF_DCMP0    8'h40
`define FRC_OFF_MAXCNT0  8'h50
`define FRC_OFF_ROUTE0   8'h80

// ============================================================
// Fields
`define FRC_CTRL_GEN     0
`define FRC_CTRL_EN_LSB  4
`define FRC_CTRL_MB_LSB  8
`define FRC_DCMP_EN      12
`define FRC_DCMP_ABOVE   13

// ============================================================
// Reset values
`define FRC_RST_WORD     32'h0000_0000
`define FRC_RST_MAXCNT   4'h0

// ============================================================
// Clock monitor: longest gap between oscillator ticks
`define FRC_CLK_MHZ      20
`define FRC_HF_GAP_NS    1000
`define FRC_LF_GAP_NS    100000
`define FRC_HF_GAP_CYC   ((`FRC_HF_GAP_NS * `FRC_CLK_MHZ) / 1000)
`define FRC_LF_GAP_CYC   ((`FRC_LF_GAP_NS * `FRC_CLK_MHZ) / 1000)

`endif

//--- rtl/frc_fault_module.v
// One fault counting module of a PWM engine.
// Assumes cycle_start is a one-cycle pulse marking each switching cycle.
`timescale 1ns/10ps
`include "frc_defines.vh"

module frc_fault_module (
    input  wire                   clk,
    input  wire                   resetn,
    input  wire                   fault_in,
    input  wire                   cycle_start,
    input  wire                   engine_en,
    input  wire                   global_en,
    input  wire [3:0]             max_count,
    output reg                    seen_q,
    output reg                    flag_q
);

// ============================================================
// Detection and counting
reg  [`FRC_CNT_W-1:0] count_q;
wire                  det;
wire                  first;
wire                  prev_clean;
wire [`FRC_CNT_W-1:0] base;
wire [`FRC_CNT_W-1:0] next_cnt;

assign det        = fault_in & global_en & engine_en;
// Only the first hit of a cycle counts, the rest are ignored
assign first      = det & (cycle_start | ~seen_q);
assign prev_clean = cycle_start & ~seen_q;
assign base       = prev_clean ? {`FRC_CNT_W{1'b0}} : count_q;
// Saturate so a long fault run cannot wrap below the limit
assign next_cnt   = (&base) ? base : base + 5'h01;

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        count_q <= 5'h00;
        seen_q  <= 1'b0;
        flag_q  <= 1'b0;
    end else if (!engine_en) begin
        count_q <= 5'h00;
        seen_q  <= 1'b0;
        flag_q  <= 1'b0;
    end else begin
        if (first)
            count_q <= next_cnt;
        else
            count_q <= base;
        if (cycle_start)
            seen_q <= det;
        else
            seen_q <= seen_q | det;
        if (first && (next_cnt > {1'b0, max_count}))
            flag_q <= 1'b1;
    end
end

endmodule // frc_fault_module

//--- rtl/frc_fault_routing.v
// Fault routing and counting top: source conditioning, routing masks,
// sixteen fault modules, cycle-by-cycle blocks and an APB register slave.
// Assumes all inputs synchronous to clk and one cycle_start pulse per
// engine switching cycle.
`timescale 1ns/10ps
`include "frc_defines.vh"

module frc_fault_routing (
    input  wire        clk,
    input  wire        resetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [9:0]  error_converter0,
    input  wire [9:0]  error_converter1,
    input  wire [9:0]  error_converter2,
    input  wire [6:0]  acmp_result,
    input  wire [3:0]  fault_pin,
    input  wire [19:0] engine_event,
    input  wire [3:0]  pcm_trip,
    input  wire [3:0]  cycle_start,
    input  wire [3:0]  zero_current,
    input  wire        hf_osc_tick,
    input  wire        lf_osc_tick,
    output reg  [3:0]  engine_output_enable,
    output reg  [48:0] acmp_threshold,
    output reg  [3:0]  shutdown_a,
    output reg  [3:0]  shutdown_b,
    output reg  [3:0]  cycle_by_cycle_cut_a,
    output reg  [3:0]  cycle_by_cycle_cut_b
);

// ============================================================
// Functions
function dcmp_hit;
    input [13:0] cfg;
    input [9:0]  s0;
    input [9:0]  s1;
    input [9:0]  s2;
    reg   [9:0]  smp;
    begin
        case (cfg[11:10])
            2'h0:    smp = s0;
            2'h1:    smp = s1;
            default: smp = s2;
        endcase
        if (cfg[`FRC_DCMP_ABOVE])
            dcmp_hit = cfg[`FRC_DCMP_EN] & (smp > cfg[9:0]);
        else
            dcmp_hit = cfg[`FRC_DCMP_EN] & (smp < cfg[9:0]);
    end
endfunction

function [11:0] gap_next;
    input [11:0] cnt;
    input        tick;
    input [11:0] lim;
    begin
        if (tick)
            gap_next = 12'h000;
        else if (cnt >= lim)
            gap_next = lim;
        else
            gap_next = cnt + 12'h001;
    end
endfunction

// Table regions are decoded for reads and for writes alike
function in_route;
    input [7:0] a;
    begin
        if (a >= `FRC_OFF_ROUTE0 && a < 8'hC0)
            in_route = 1'b1;
        else
            in_route = 1'b0;
    end
endfunction

function in_maxcnt;
    input [7:0] a;
    begin
        if (a >= `FRC_OFF_MAXCNT0 && a < 8'h60)
            in_maxcnt = 1'b1;
        else
            in_maxcnt = 1'b0;
    end
endfunction

function in_dcmp;
    input [7:0] a;
    begin
        if (a >= `FRC_OFF_DCMP0 && a < 8'h50)
            in_dcmp = 1'b1;
        else
            in_dcmp = 1'b0;
    end
endfunction

// ============================================================
// Configuration registers
reg        global_en_q;
reg [3:0]  match_b_q;
reg [19:0] evt_en_q;
reg [7:0]  ext_cfg_q;
reg [13:0] acmp_cfg_q;
reg [13:0] dcmp_cfg_q [0:3];
reg [15:0] maxcnt_q   [0:3];
reg [24:0] route_q    [0:15];

// One loop variable per process so none has two drivers
integer i;
integer i_sd;
integer i_cfg;

// ============================================================
// Source conditioning
reg  [3:0]  dcmp_q;
reg  [3:0]  zc_seen_q;
reg  [3:0]  dcm_q;
reg  [11:0] hf_gap_q;
reg  [11:0] lf_gap_q;
wire [31:0] hf_lim_w = `FRC_HF_GAP_CYC;
wire [31:0] lf_lim_w = `FRC_LF_GAP_CYC;
// Both limits fit in twelve bits, so the upper bits are cut on purpose
wire [11:0] hf_lim   = hf_lim_w[11:0];
wire [11:0] lf_lim   = lf_lim_w[11:0];
wire        hf_fail = (hf_gap_q >= hf_lim);
wire        lf_fail = (lf_gap_q >= lf_lim);
wire [3:0]  ext_src = (fault_pin ^ ext_cfg_q[7:4]) & ext_cfg_q[3:0];
wire [6:0]  acmp_src = (acmp_result ^ acmp_cfg_q[13:7]) & acmp_cfg_q[6:0];
wire [19:0] evt_act = engine_event & evt_en_q;
wire [3:0]  eng_src;
wire [24:0] src;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_eng_src
        assign eng_src[g] = |evt_act[5*g+4:5*g];
    end
endgenerate

assign src = {dcm_q, lf_fail, hf_fail, eng_src, ext_src, acmp_src, dcmp_q};

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        dcmp_q    <= 4'h0;
        zc_seen_q <= 4'h0;
        dcm_q     <= 4'h0;
        hf_gap_q  <= 12'h000;
        lf_gap_q  <= 12'h000;
    end else begin
        for (i = 0; i < 4; i = i + 1) begin
            dcmp_q[i] <= dcmp_hit(dcmp_cfg_q[i], error_converter0,
                                  error_converter1, error_converter2);
            // A zero crossing in the same cycle as the boundary is kept
            if (cycle_start[i]) begin
                dcm_q[i]     <= zc_seen_q[i] | zero_current[i];
                zc_seen_q[i] <= 1'b0;
            end else begin
                zc_seen_q[i] <= zc_seen_q[i] | zero_current[i];
            end
        end
        hf_gap_q <= gap_next(hf_gap_q, hf_osc_tick, hf_lim);
        lf_gap_q <= gap_next(lf_gap_q, lf_osc_tick, lf_lim);
    end
end

// ============================================================
// Routing and fault modules
wire [15:0] fault_in;
wire [15:0] seen;
wire [15:0] flag;

generate
    for (g = 0; g < 16; g = g + 1) begin : g_mod
        if (g % 4 == 0) begin : g_cbc
            // Peak current trips join the cycle-by-cycle module input
            assign fault_in[g] = (|(src & route_q[g])) | pcm_trip[g/4];
        end else begin : g_std
            assign fault_in[g] = |(src & route_q[g]);
        end
        frc_fault_module u_mod (
            .clk         (clk),
            .resetn      (resetn),
            .fault_in    (fault_in[g]),
            .cycle_start (cycle_start[g/4]),
            .engine_en   (engine_output_enable[g/4]),
            .global_en   (global_en_q),
            .max_count   (maxcnt_q[g/4][4*(g%4)+3 -: 4]),
            .seen_q      (seen[g]),
            .flag_q      (flag[g])
        );
    end
endgenerate

// ============================================================
// Shutdown and cycle-by-cycle block
// Module order per engine: 0 cycle-by-cycle, 1 AB, 2 A, 3 B
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        shutdown_a           <= 4'h0;
        shutdown_b           <= 4'h0;
        cycle_by_cycle_cut_a <= 4'h0;
        cycle_by_cycle_cut_b <= 4'h0;
    end else begin
        for (i_sd = 0; i_sd < 4; i_sd = i_sd + 1) begin
            shutdown_a[i_sd] <= flag[4*i_sd] | flag[4*i_sd+1] | flag[4*i_sd+2];
            shutdown_b[i_sd] <= flag[4*i_sd] | flag[4*i_sd+1] | flag[4*i_sd+3];
            // One block per engine: cut the pulse for the rest of the cycle
            cycle_by_cycle_cut_a[i_sd] <= seen[4*i_sd] & ~cycle_start[i_sd];
            cycle_by_cycle_cut_b[i_sd] <= seen[4*i_sd] & ~cycle_start[i_sd] & match_b_q[i_sd];
        end
    end
end

// ============================================================
// APB slave: one wait state, pready from a flop
wire       acc  = psel & penable;
wire       done = acc & pready;
wire       wr   = done & pwrite;
wire       take = acc & ~pready;
wire [3:0] idx  = paddr[5:2];
reg [31:0] rd_d;
reg        hit_d;

always @* begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    if (paddr[1:0] != 2'h0) begin
        hit_d = 1'b0;
    end else if (in_route(paddr)) begin
        rd_d = {7'h00, route_q[idx]};
    end else if (in_maxcnt(paddr)) begin
        rd_d = {16'h0000, maxcnt_q[idx[1:0]]};
    end else if (in_dcmp(paddr)) begin
        rd_d = {18'h00000, dcmp_cfg_q[idx[1:0]]};
    end else begin
        case (paddr)
            `FRC_OFF_CTRL:
                rd_d = {20'h00000, match_b_q, engine_output_enable, 3'h0, global_en_q};
            `FRC_OFF_STATUS:
                rd_d = {10'h000, dcm_q, lf_fail, hf_fail, flag};
            `FRC_OFF_SRC:      rd_d = {7'h00, src};
            `FRC_OFF_EVT_EN:   rd_d = {12'h000, evt_en_q};
            `FRC_OFF_EXT_CFG:  rd_d = {24'h000000, ext_cfg_q};
            `FRC_OFF_ACMP_CFG: rd_d = {17'h00000, acmp_cfg_q[13:7], 1'b0, acmp_cfg_q[6:0]};
            `FRC_OFF_ATHR_LO:
                rd_d = {1'b0, acmp_threshold[27:21], 1'b0, acmp_threshold[20:14],
                        1'b0, acmp_threshold[13:7], 1'b0, acmp_threshold[6:0]};
            `FRC_OFF_ATHR_HI:
                rd_d = {9'h000, acmp_threshold[48:42], 1'b0, acmp_threshold[41:35],
                        1'b0, acmp_threshold[34:28]};
            default:           hit_d = 1'b0;
        endcase
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= `FRC_RST_WORD;
    end else begin
        // Registered answer gives exactly one wait state
        pready  <= take;
        pslverr <= take & ~hit_d;
        // Read data is taken once and then held for the master
        if (take && !pwrite)
            prdata <= rd_d;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        global_en_q          <= 1'b0;
        engine_output_enable <= 4'h0;
        match_b_q            <= 4'h0;
        evt_en_q             <= 20'h00000;
        ext_cfg_q            <= 8'h00;
        acmp_cfg_q           <= 14'h0000;
        acmp_threshold       <= 49'h0_0000_0000_0000;
        for (i_cfg = 0; i_cfg < 4; i_cfg = i_cfg + 1) begin
            dcmp_cfg_q[i_cfg] <= 14'h0000;
            maxcnt_q[i_cfg]   <= {4{`FRC_RST_MAXCNT}};
        end
        for (i_cfg = 0; i_cfg < 16; i_cfg = i_cfg + 1)
            route_q[i_cfg] <= 25'h000_0000;
    end else if (wr && hit_d) begin
        if (in_route(paddr)) begin
            route_q[idx] <= pwdata[24:0];
        end else if (in_maxcnt(paddr)) begin
            maxcnt_q[idx[1:0]] <= pwdata[15:0];
        end else if (in_dcmp(paddr)) begin
            dcmp_cfg_q[idx[1:0]] <= pwdata[13:0];
        end else begin
            case (paddr)
                `FRC_OFF_CTRL: begin
                    global_en_q          <= pwdata[`FRC_CTRL_GEN];
                    engine_output_enable <= pwdata[`FRC_CTRL_EN_LSB+3:`FRC_CTRL_EN_LSB];
                    match_b_q            <= pwdata[`FRC_CTRL_MB_LSB+3:`FRC_CTRL_MB_LSB];
                end
                `FRC_OFF_EVT_EN:   evt_en_q <= pwdata[19:0];
                `FRC_OFF_EXT_CFG:  ext_cfg_q <= pwdata[7:0];
                `FRC_OFF_ACMP_CFG: acmp_cfg_q <= {pwdata[14:8], pwdata[6:0]};
                `FRC_OFF_ATHR_LO:
                    acmp_threshold[27:0] <= {pwdata[30:24], pwdata[22:16],
                                             pwdata[14:8], pwdata[6:0]};
                `FRC_OFF_ATHR_HI:
                    acmp_threshold[48:28] <= {pwdata[22:16], pwdata[14:8], pwdata[6:0]};
                default: global_en_q <= global_en_q;
            endcase
        end
    end
end

endmodule // frc_fault_routing

//--- testbench/frc_checker_asserts.sv
// Checker for the fault routing top: APB timing, register effects and
// the clearing of shutdown outputs.
// Assumes one clock domain and the map of frc_defines.vh.
`timescale 1ns/10ps
`include "frc_defines.vh"
module frc_checker (
    input wire        clk,
    input wire        resetn,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  engine_output_enable,
    input wire [48:0] acmp_threshold,
    input wire [3:0]  shutdown_a,
    input wire [3:0]  shutdown_b
);
    wire       acc  = psel && penable;
    wire       done = acc && pready;
    wire       wctl = done && pwrite && paddr == `FRC_OFF_CTRL;
    wire [3:0] w_en = pwdata[7:4];
    wire [6:0] w_th = pwdata[6:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ============================================================
    // Bus timing
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; acc && !pready; endsequence
    property p_one_wait; s_setup ##1 s_wait |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_rdy_pulse; pready |-> acc ##1 !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready not a pulse");
    property p_bad_addr; done && (paddr[1:0] != 2'b00 || paddr == 8'hFC) |-> pslverr; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("no error on bad address");
    property p_ctl_ok; done && paddr == `FRC_OFF_CTRL |-> !pslverr; endproperty
    a_ctl_ok: assert property (p_ctl_ok) else $error("error on control access");
    property p_rd_hold; !(acc && !pready && !pwrite) |=> $stable(prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // ============================================================
    // Register effects and flag clearing
    property p_en_wr; wctl |=> engine_output_enable == $past(w_en); endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable not written");
    property p_en_hold; !wctl |=> $stable(engine_output_enable); endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved");
    property p_thr; done && pwrite && paddr == `FRC_OFF_ATHR_LO
        |=> acmp_threshold[6:0] == $past(w_th); endproperty
    a_thr: assert property (p_thr) else $error("threshold not written");
    // Flag clears while the engine is off, shutdown a cycle later
    property p_clear; ((shutdown_a | shutdown_b) & ~$past(engine_output_enable)
        & ~$past(engine_output_enable, 2)) == 4'h0; endproperty
    a_clear: assert property (p_clear) else $error("shutdown kept");
endmodule // frc_checker
bind frc_fault_routing frc_checker u_chk (.clk, .resetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .engine_output_enable,
    .acmp_threshold, .shutdown_a, .shutdown_b);

//--- testbench/frc_pwm_model.sv
// Model of the four PWM engines and the ticks of the two oscillators.
// Assumes 16-clock switching cycles; engine e starts at count 4e.
`timescale 1ns/10ps
module frc_pwm_model (
    input  wire       clk,
    input  wire       resetn,
    input  wire       stop_ticks,
    output reg  [3:0] cycle_start,
    output reg  [3:0] zero_current,
    output reg        hf_osc_tick,
    output reg        lf_osc_tick
);
    reg [3:0] cyc_q;
    reg [9:0] tick_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_q <= 4'h0;
            tick_q <= 10'h000;
            cycle_start <= 4'h0;
            zero_current <= 4'h0;
            hf_osc_tick <= 1'b0;
            lf_osc_tick <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 4'h1;
            tick_q <= (tick_q == 10'd999) ? 10'h000 : tick_q + 10'h001;
            cycle_start <= {cyc_q == 4'hC, cyc_q == 4'h8, cyc_q == 4'h4, cyc_q == 4'h0};
            // Only engine 3 runs discontinuous
            zero_current <= {cyc_q == 4'h8, 3'b000};
            hf_osc_tick <= !stop_ticks && (tick_q % 10) == 0;
            lf_osc_tick <= !stop_ticks && tick_q == 10'h000;
        end
    end
endmodule // frc_pwm_model

//--- testbench/tb.sv
// Self-checking bench for the fault routing top: APB access, random
// routing cases with counting limits, flag clearing, oscillator loss.
// Assumes frc_pwm_model supplies switching cycles and oscillator ticks.
`timescale 1ns/10ps
`include "frc_defines.vh"
module tb;
    reg         clk = 1'b0;
    reg         resetn = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [31:0] pwdata = 32'h0;
    reg  [9:0]  ec0 = 10'h0, ec1 = 10'h0, ec2 = 10'h0;
    reg  [6:0]  acmp = 7'h00, amask = 7'h00;
    reg  [3:0]  pins = 4'h0, pcm = 4'h0, pmask = 4'h0, cmask = 4'h0;
    reg  [19:0] evt = 20'h0;
    reg         fv = 1'b0, stop = 1'b0, rerr;
    reg  [31:0] rdat, rnd, r;
    integer     seed = 32'h235F70EB;
    integer     mismatches = 0;
    integer     samples_checked = 0;
    integer     i, m, e, k, sb, lim;
    wire [31:0] prdata;
    wire        pready, pslverr, hft, lft;
    wire [3:0]  cs, zc, eoe, sda, sdb, cca, ccb;
    wire [48:0] thr;
    frc_fault_routing DUT (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .error_converter0(ec0),
        .error_converter1(ec1), .error_converter2(ec2), .acmp_result(acmp),
        .fault_pin(pins), .engine_event(evt), .pcm_trip(pcm), .cycle_start(cs),
        .zero_current(zc), .hf_osc_tick(hft), .lf_osc_tick(lft),
        .engine_output_enable(eoe), .acmp_threshold(thr), .shutdown_a(sda),
        .shutdown_b(sdb), .cycle_by_cycle_cut_a(cca), .cycle_by_cycle_cut_b(ccb));
    frc_pwm_model u_pwm (.clk(clk), .resetn(resetn), .stop_ticks(stop), .cycle_start(cs),
        .zero_current(zc), .hf_osc_tick(hft), .lf_osc_tick(lft));
    always #25 clk = ~clk;
    // ============================================================
    // Stimulus: unrouted sources toggle at random, the chosen one follows fv
    always @(posedge clk) begin
        rnd = $random(seed);
        ec0 <= rnd[9:0];
        ec1 <= rnd[19:10];
        ec2 <= rnd[29:20];
        evt <= rnd[31:12];
        pins <= (rnd[3:0] & ~pmask) | (pmask & {4{fv}});
        acmp <= (rnd[26:20] & ~amask) | (amask & {7{fv}});
        pcm <= cmask & {4{fv}};
    end
    // ============================================================
    // Tasks
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 20) mismatches = mismatches + 1;
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    function [1:0] exp_sd(input integer kk);
        exp_sd = (kk <= 1) ? 2'b11 : (kk == 2) ? 2'b10 : 2'b01;
    endfunction
    // One switching cycle of engine e, faulted for three clocks or clean
    task fcyc(input v);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            while (cs[e] !== 1'b1 && n < 40) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 40) mismatches = mismatches + 1;
            repeat (2) @(posedge clk);
            fv <= v;
            repeat (3) @(posedge clk);
            fv <= 1'b0;
        end
    endtask
    task stat(input [15:0] exp);
        begin
            apb(0, `FRC_OFF_STATUS, 32'h0);
            chk(rdat[15:0], exp);
        end
    endtask
    task run_case;
        begin
            e = m / 4;
            k = m % 4;
            cmask <= (k == 0) ? (4'h1 << e) : 4'h0;
            amask <= (k != 0 && sb < 7) ? (7'h01 << sb) : 7'h00;
            pmask <= (k != 0 && sb >= 7) ? (4'h1 << (sb - 7)) : 4'h0;
            apb(1, `FRC_OFF_MAXCNT0 + 4 * e, lim << (4 * k));
            apb(1, `FRC_OFF_ROUTE0 + 4 * m, (k == 0) ? 0 : 1 << (4 + sb));
            apb(1, `FRC_OFF_CTRL, 1 << (4 + e));
            repeat (lim + 1) fcyc(1);
            stat(16'h0);
            apb(1, `FRC_OFF_CTRL, 1 | (1 << (4 + e)) | (1 << (8 + e)));
            @(negedge clk);
            chk(eoe, 4'h1 << e);
            repeat (lim) fcyc(1);
            fcyc(0);
            repeat (lim) fcyc(1);
            stat(16'h0);
            fcyc(1);
            @(negedge clk);
            chk({cca[e], ccb[e]}, (k == 0) ? 2'b11 : 2'b00);
            stat(16'h1 << m);
            chk({sda[e], sdb[e]}, exp_sd(k));
            apb(1, `FRC_OFF_CTRL, 1 << (4 + e));
            stat(16'h1 << m);
            apb(1, `FRC_OFF_CTRL, 0);
            stat(16'h0);
            chk({sda[e], sdb[e]}, 2'b00);
            apb(1, `FRC_OFF_ROUTE0 + 4 * m, 0);
        end
    endtask
    task results;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        apb(0, `FRC_OFF_CTRL, 32'h0);
        chk(rdat, `FRC_RST_WORD);
        apb(0, 8'hFC, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h8000_0000);
        apb(1, 8'h02, 32'h0000_00F1);
        chk({31'h0, rerr}, 32'h1);
        @(negedge clk);
        chk(eoe, 4'h0);
        apb(1, `FRC_OFF_EXT_CFG, 32'h0000_000F);
        apb(1, `FRC_OFF_ACMP_CFG, 32'h0000_007F);
        apb(1, `FRC_OFF_ATHR_LO, 32'h1234_5678);
        @(negedge clk);
        chk(thr[27:0], {7'h12, 7'h34, 7'h56, 7'h78});
        for (i = 0; i < 12; i = i + 1) begin
            r = $random(seed);
            // Corner cases first: each module type, limits 15 and 0
            m = (i < 4) ? 5 * i : r[3:0];
            lim = (i == 0) ? 15 : (i < 4) ? 0 : r[5:4];
            sb = (i < 4) ? 10 - i : r[13:8] % 11;
            run_case;
        end
        apb(0, `FRC_OFF_STATUS, 32'h0);
        chk(rdat[21:16], 6'h20);
        stop <= 1'b1;
        repeat (2100) @(posedge clk);
        apb(0, `FRC_OFF_STATUS, 32'h0);
        chk(rdat[21:16], 6'h23);
        results;
    end
    initial begin
        #(50 * 40000);
        mismatches = mismatches + 1;
        results;
    end
endmodule // tb
